/* logic/mmtimer_pkg.sv */
package mmtimer_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] start_first_off = 8'h00;
  localparam logic [7:0] start_second_off = 8'h04;
  localparam logic [7:0] cutoff_ctrl_off = 8'h08;
  localparam logic [7:0] irq_flags_off = 8'h0c;
  localparam logic [7:0] pin_status_off = 8'h10;
  localparam logic [7:0] a_mode_base = 8'h20;
  localparam logic [7:0] a_count_base = 8'h40;
  localparam logic [7:0] b_mode_base = 8'h60;
  localparam logic [7:0] b_count_base = 8'h80;
  localparam int num_a = 5;
  localparam int num_b = 6;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int b_run_lsb = 5;
  localparam int cutoff_en_bit = 0;
  localparam int b_irq_lsb = 8;
  localparam int ovf_bit = 3;
  localparam int rsv_bit = 2;
  localparam int src_lsb = 6;
  localparam int rst_mode = 0;
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] all_ones = 16'hffff;
  localparam logic [15:0] all_zero = 16'h0000;
  // Operating mode field, bits 1:0
  localparam logic [1:0] md_timer = 2'h0;
  localparam logic [1:0] md_event = 2'h1;
  localparam logic [1:0] md_oneshot = 2'h2;
  localparam logic [1:0] md_pwm = 2'h3;
  localparam logic [1:0] md_measure = 2'h2;
  // Mode bit 4 in group A event mode: count up when set
  localparam int a_up_bit = 4;
  // Mode bit 5 in group B measure mode: width (1) or period (0)
  localparam int b_width_bit = 5;
endpackage

/* logic/mmtimer.sv */
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
// How it works
// [RQ1] Software configures channel before setting start bit
// [RQ2] Channels idle after reset until started
// [RQ3] Group A timer read on reload gives FFFFh
// [RQ4] Stopped channel reads back the written value
// [RQ5] Event underflow reads FFFFh, overflow reads 0000h
// [RQ6] Cutoff plus low nmi floats A1,A2,A4 outputs
// [RQ7] One-shot stop reloads counter, output low
// [RQ8] One-shot stop sets irq one cycle later
// [RQ9] One-shot output synchronized to count source
// [RQ10] Entering one-shot mode from timer/event sets irq
// [RQ11] Retrigger counts once more, then reloads; code reloads on the first tick after the retrigger, with no extra count
// [RQ12] Retrigger spaced over one count-source cycle
// [RQ13] Entering PWM mode from timer/event sets irq
// [RQ14] PWM stop: high output drops, irq set
// [RQ15] Group B start bits at bits 5-7 of both
// [RQ16] Group B timer/event read on reload gives FFFFh
// [RQ17] Overflow clear needs same mode rewrite, reserved 0
// [RQ18] Measure edge and overflow raise irq; flag marks overflow
// [RQ19] Overflow clear needs write then next count source
// [RQ20] First measure edge loads reload, no irq
// [RQ21] Measure counter starts undefined, may overflow
// [RQ22] Width measure alternates levels without marking
// [RQ23] Sixteen-bit counters, one start bit each
module mmtimer
  import mmtimer_pkg::*;
#(
  parameter int width = 16
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [num_a-1:0] a_tick, // Group A count source pulses
  input wire logic [num_a-1:0] group_a_input_pin, // Event or trigger input
  input wire logic [num_b-1:0] b_tick, // Group B count source pulses
  input wire logic [num_b-1:0] b_pulse_in, // Event or measured pulse input
  input wire logic nmi_n, // Non-maskable interrupt pin
  output logic [num_a-1:0] group_a_output_pin, // Timer outputs
  output logic [num_a-1:0] group_a_output_oe_n, // Output enables, low drives
  output logic [num_a-1:0] group_a_irq_control, // Group A request flags
  output logic [num_b-1:0] group_b_irq_control // Group B request flags
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] a_mode [num_a];
  logic [7:0] next_a_mode [num_a];
  logic [width-1:0] a_cnt [num_a];
  logic [width-1:0] next_a_cnt [num_a];
  logic [width-1:0] a_rld [num_a];
  logic [width-1:0] next_a_rld [num_a];
  logic [width-1:0] a_snap [num_a];
  logic [width-1:0] next_a_snap [num_a];
  logic [num_a-1:0] a_run, next_a_run, a_out, next_a_out, a_fire, next_a_fire;
  logic [num_a-1:0] a_retrig, next_a_retrig, a_trig_q, next_a_trig_q;
  logic [num_a-1:0] a_irq, next_a_irq, a_stop_irq, next_a_stop_irq;
  logic [num_a-1:0] a_oe_n, next_a_oe_n;
  logic [7:0] b_mode [num_b];
  logic [7:0] next_b_mode [num_b];
  logic [width-1:0] b_cnt [num_b];
  logic [width-1:0] next_b_cnt [num_b];
  logic [width-1:0] b_rld [num_b];
  logic [width-1:0] next_b_rld [num_b];
  logic [width-1:0] b_snap [num_b];
  logic [width-1:0] next_b_snap [num_b];
  logic [num_b-1:0] b_run, next_b_run, b_irq, next_b_irq, b_pin_q, next_b_pin_q;
  logic [num_b-1:0] b_first, next_b_first, b_clr_arm, next_b_clr_arm;
  logic cutoff_en, next_cutoff_en;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;

  // A request completes one cycle after it is seen; waitrequest is high meanwhile
  wire logic req = (avs_read | avs_write) & ~ack;
  wire logic wr = avs_write & req;
  wire logic rd = avs_read & req;
  wire logic cut = cutoff_en & ~nmi_n;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input int i);
    hit = addr == base + 8'(4 * i);
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic be0);
    merge8 = be0 ? d[7:0] : old;
  endfunction

  function automatic logic [width-1:0] merge16(input logic [width-1:0] old,
                                               input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // Group A next state
  // ---------------------------------------------------------------
  always_comb begin
    logic trig;
    logic [1:0] md;
    logic [7:0] nm;
    trig = 1'b0;
    md = 2'h0;
    nm = 8'h00;
    next_a_run = a_run;
    next_a_out = a_out;
    next_a_fire = 1'b0 ? a_fire : '0;
    next_a_retrig = a_retrig;
    next_a_irq = a_irq;
    next_a_stop_irq = '0;
    next_a_trig_q = group_a_input_pin;
    next_cutoff_en = cutoff_en;
    for (int i = 0; i < num_a; i++) begin
      next_a_mode[i] = a_mode[i];
      next_a_cnt[i] = a_cnt[i];
      next_a_rld[i] = a_rld[i];
      next_a_snap[i] = a_cnt[i];
      md = a_mode[i][1:0];
      trig = group_a_input_pin[i] & ~a_trig_q[i];
      // Channels only move while started
      if (a_run[i]) begin // RQ2
        unique case (md)
          md_timer, md_event: begin
            if (a_tick[i] || (md == md_event && trig)) begin
              if (md == md_event && a_mode[i][a_up_bit]) begin
                if (a_cnt[i] == all_ones) begin
                  next_a_cnt[i] = a_rld[i];
                  next_a_snap[i] = all_zero; // RQ5
                  next_a_irq[i] = 1'b1;
                  next_a_out[i] = ~a_out[i];
                end else begin
                  next_a_cnt[i] = a_cnt[i] + 16'h0001;
                end
              end else if (a_cnt[i] == all_zero) begin
                next_a_cnt[i] = a_rld[i];
                next_a_snap[i] = all_ones; // RQ3 RQ5
                next_a_irq[i] = 1'b1;
                next_a_out[i] = ~a_out[i];
              end else begin
                next_a_cnt[i] = a_cnt[i] - 16'h0001;
              end
            end
          end
          md_oneshot, md_pwm: begin
            if (trig) begin
              if (a_fire[i]) begin
                next_a_retrig[i] = 1'b1; // RQ11 RQ12
              end
              next_a_fire[i] = 1'b1;
            end else begin
              next_a_fire[i] = a_fire[i];
            end
            // Apart from a stop write, output changes only on a count-source tick
            if (a_tick[i] && a_fire[i]) begin // RQ9
              next_a_out[i] = 1'b1;
              if (a_retrig[i]) begin
                next_a_cnt[i] = a_rld[i]; // RQ11
                next_a_retrig[i] = 1'b0;
              end else if (a_cnt[i] == all_zero) begin
                next_a_cnt[i] = a_rld[i];
                next_a_out[i] = md == md_pwm ? ~a_out[i] : 1'b0;
                next_a_fire[i] = md == md_pwm && !a_out[i] ? 1'b1 : trig;
                next_a_irq[i] = 1'b1;
              end else begin
                next_a_cnt[i] = a_cnt[i] - 16'h0001;
              end
            end
          end
        endcase
      end
      if (a_stop_irq[i]) begin
        next_a_irq[i] = 1'b1; // RQ8
      end
      if (wr && hit(avs_address, a_mode_base, i)) begin
        nm = merge8(a_mode[i], avs_writedata, avs_byteenable[0]);
        next_a_mode[i] = nm;
        // Entering pulse modes from timer or event raises a request
        if (nm[1] && !a_mode[i][1]) begin
          next_a_irq[i] = 1'b1; // RQ10 RQ13
        end
      end
      if (wr && hit(avs_address, a_count_base, i)) begin
        next_a_rld[i] = merge16(a_rld[i], avs_writedata, avs_byteenable);
        if (!a_run[i]) begin
          next_a_cnt[i] = merge16(a_cnt[i], avs_writedata, avs_byteenable); // RQ4
        end
      end
      if (wr && avs_address == start_first_off && avs_byteenable[0]) begin
        next_a_run[i] = avs_writedata[i]; // RQ23
        if (a_run[i] && !avs_writedata[i] && md[1]) begin
          next_a_fire[i] = 1'b0;
          next_a_retrig[i] = 1'b0;
          next_a_cnt[i] = a_rld[i]; // RQ7
          next_a_out[i] = 1'b0; // RQ7 RQ14
          if (md == md_oneshot || a_out[i]) begin
            next_a_stop_irq[i] = 1'b1; // RQ8 RQ14
          end
        end
      end
      if (wr && avs_address == irq_flags_off && avs_byteenable[0] && !avs_writedata[i]) begin
        next_a_irq[i] = next_a_irq[i] & (a_stop_irq[i] | (a_run[i] & a_tick[i]));
      end
      next_a_oe_n[i] = cut && (i == 1 || i == 2 || i == 4); // RQ6
    end
    if (wr && avs_address == cutoff_ctrl_off && avs_byteenable[0]) begin
      next_cutoff_en = avs_writedata[cutoff_en_bit];
    end
  end

  // ---------------------------------------------------------------
  // Group B next state
  // ---------------------------------------------------------------
  always_comb begin
    logic edge_hit;
    logic [7:0] nm;
    edge_hit = 1'b0;
    nm = 8'h00;
    next_b_run = b_run;
    next_b_irq = b_irq;
    next_b_pin_q = b_pulse_in;
    next_b_first = b_first;
    next_b_clr_arm = b_clr_arm;
    for (int i = 0; i < num_b; i++) begin
      next_b_mode[i] = b_mode[i];
      next_b_cnt[i] = b_cnt[i];
      next_b_rld[i] = b_rld[i];
      next_b_snap[i] = b_cnt[i];
      // Width mode takes both edges, period mode rising edges only
      edge_hit = b_mode[i][b_width_bit] ? (b_pulse_in[i] ^ b_pin_q[i])
                                        : (b_pulse_in[i] & ~b_pin_q[i]); // RQ22
      if (b_run[i]) begin // RQ2
        if (b_mode[i][1:0] == md_measure) begin
          if (edge_hit) begin
            next_b_rld[i] = b_cnt[i]; // RQ20
            next_b_cnt[i] = all_zero;
            next_b_first[i] = 1'b0;
            if (!b_first[i]) begin
              next_b_irq[i] = 1'b1; // RQ18 RQ20
            end
          end else if (b_tick[i]) begin
            next_b_cnt[i] = b_cnt[i] + 16'h0001; // RQ21
            if (b_cnt[i] == all_ones) begin
              next_b_mode[i][ovf_bit] = 1'b1; // RQ18
              next_b_irq[i] = 1'b1;
              next_b_clr_arm[i] = 1'b0;
            end else if (b_clr_arm[i]) begin
              next_b_mode[i][ovf_bit] = 1'b0; // RQ19
              next_b_clr_arm[i] = 1'b0;
            end
          end
        end else if (b_tick[i] || (b_mode[i][1:0] == md_event && edge_hit)) begin
          if (b_cnt[i] == all_zero) begin
            next_b_cnt[i] = b_rld[i];
            next_b_snap[i] = all_ones; // RQ16
            next_b_irq[i] = 1'b1;
          end else begin
            next_b_cnt[i] = b_cnt[i] - 16'h0001;
          end
        end
      end
      if (wr && hit(avs_address, b_mode_base, i) && avs_byteenable[0]) begin
        nm = avs_writedata[7:0];
        if (b_run[i]) begin
          // Only a rewrite with the same fields arms the overflow clear
          if (nm[1:0] == b_mode[i][1:0] && nm[7:4] == b_mode[i][7:4] && !nm[rsv_bit]) begin
            next_b_clr_arm[i] = b_mode[i][ovf_bit]; // RQ17 RQ19
          end
        end else begin
          next_b_mode[i] = {nm[7:4], 1'b0, nm[2:0]};
        end
      end
      if (wr && hit(avs_address, b_count_base, i)) begin
        next_b_rld[i] = merge16(b_rld[i], avs_writedata, avs_byteenable);
        if (!b_run[i]) begin
          next_b_cnt[i] = merge16(b_cnt[i], avs_writedata, avs_byteenable); // RQ4
        end
      end
      if (wr && avs_byteenable[0] &&
          avs_address == (i < 3 ? start_first_off : start_second_off)) begin
        next_b_run[i] = avs_writedata[b_run_lsb + (i % 3)]; // RQ15
        if (!b_run[i]) begin
          next_b_first[i] = 1'b1;
        end
      end
      if (wr && avs_address == irq_flags_off && avs_byteenable[1] &&
          !avs_writedata[b_irq_lsb + i]) begin
        next_b_irq[i] = next_b_irq[i] & b_run[i] & (b_tick[i] | b_pulse_in[i] ^ b_pin_q[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus read path
  // ---------------------------------------------------------------
  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    if (rd) begin
      next_rdata = 32'h00000000;
      if (avs_address == start_first_off) begin
        next_rdata[7:0] = {b_run[2:0], a_run};
      end else if (avs_address == start_second_off) begin
        next_rdata[7:0] = {b_run[5:3], 5'h00};
      end else if (avs_address == cutoff_ctrl_off) begin
        next_rdata[cutoff_en_bit] = cutoff_en;
      end else if (avs_address == irq_flags_off) begin
        next_rdata[15:0] = {2'h0, b_irq, 3'h0, a_irq};
      end else if (avs_address == pin_status_off) begin
        next_rdata[15:0] = {3'h0, a_oe_n, 3'h0, a_out};
      end
      for (int i = 0; i < num_a; i++) begin
        if (hit(avs_address, a_mode_base, i)) next_rdata[7:0] = a_mode[i];
        if (hit(avs_address, a_count_base, i)) next_rdata[15:0] = a_snap[i]; // RQ3 RQ5
      end
      for (int i = 0; i < num_b; i++) begin
        if (hit(avs_address, b_mode_base, i)) next_rdata[7:0] = b_mode[i];
        if (hit(avs_address, b_count_base, i)) begin
          next_rdata[15:0] = b_mode[i][1:0] == md_measure ? b_rld[i] : b_snap[i]; // RQ16
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      a_run <= '0;
      b_run <= '0;
      a_out <= '0;
      a_fire <= '0;
      a_retrig <= '0;
      a_trig_q <= '0;
      a_irq <= '0;
      a_stop_irq <= '0;
      a_oe_n <= '0;
      b_irq <= '0;
      b_pin_q <= '0;
      b_first <= '0;
      b_clr_arm <= '0;
      cutoff_en <= 1'b0;
      rdata <= 32'h00000000;
      ack <= 1'b0;
      for (int i = 0; i < num_a; i++) begin
        a_mode[i] <= mode_reset;
        a_cnt[i] <= count_reset;
        a_rld[i] <= count_reset;
        a_snap[i] <= count_reset;
      end
      for (int i = 0; i < num_b; i++) begin
        b_mode[i] <= mode_reset;
        b_cnt[i] <= count_reset;
        b_rld[i] <= count_reset;
        b_snap[i] <= count_reset;
      end
    end else begin
      a_run <= next_a_run;
      b_run <= next_b_run;
      a_out <= next_a_out;
      a_fire <= next_a_fire;
      a_retrig <= next_a_retrig;
      a_trig_q <= next_a_trig_q;
      a_irq <= next_a_irq;
      a_stop_irq <= next_a_stop_irq;
      a_oe_n <= next_a_oe_n;
      b_irq <= next_b_irq;
      b_pin_q <= next_b_pin_q;
      b_first <= next_b_first;
      b_clr_arm <= next_b_clr_arm;
      cutoff_en <= next_cutoff_en;
      rdata <= next_rdata;
      ack <= next_ack;
      a_mode <= next_a_mode;
      a_cnt <= next_a_cnt;
      a_rld <= next_a_rld;
      a_snap <= next_a_snap;
      b_mode <= next_b_mode;
      b_cnt <= next_b_cnt;
      b_rld <= next_b_rld;
      b_snap <= next_b_snap;
    end
  end

  always_comb begin
    avs_readdata = rdata;
    avs_waitrequest = ~ack;
    group_a_output_pin = a_out;
    group_a_output_oe_n = a_oe_n;
    group_a_irq_control = a_irq;
    group_b_irq_control = b_irq;
  end
endmodule // mmtimer

/* bench/mmtimer_assertions.sv */
`timescale 1ns/100ps
module mmtimer_assertions
  import mmtimer_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [num_a-1:0] a_tick, // A ticks
  input wire logic [num_a-1:0] group_a_input_pin, // A inputs
  input wire logic [num_b-1:0] b_tick, // B ticks
  input wire logic [num_b-1:0] b_pulse_in, // B pulses
  input wire logic nmi_n, // Interrupt pin
  input wire logic [num_a-1:0] group_a_output_pin, // A outputs
  input wire logic [num_a-1:0] group_a_output_oe_n, // A enables
  input wire logic [num_a-1:0] group_a_irq_control, // A flags
  input wire logic [num_b-1:0] group_b_irq_control // B flags
);
  // ------------
  // Shadow of accepted writes
  // ------------
  logic [num_a-1:0] run_a;
  logic [num_a-1:0] next_run_a;
  logic cut;
  logic next_cut;
  logic seen_wr;
  logic next_seen_wr;
  wire logic acc_wr = avs_write && !avs_waitrequest;
  always_comb begin
    next_run_a = run_a;
    next_cut = cut;
    next_seen_wr = seen_wr || acc_wr;
    if (acc_wr && avs_address == start_first_off) begin
      next_run_a = avs_writedata[num_a-1:0];
    end
    if (acc_wr && avs_address == cutoff_ctrl_off) begin
      next_cut = avs_writedata[cutoff_en_bit];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_a <= '0;
      cut <= 1'b0;
      seen_wr <= 1'b0;
    end else begin
      run_a <= next_run_a;
      cut <= next_cut;
      seen_wr <= next_seen_wr;
    end
  end
  // ------------
  // Properties
  // ------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bus_ack: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no ack after one wait");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack too long");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("ack without request");
  a_idle_irq: assert property (!(seen_wr || avs_write) |->
    group_a_irq_control == '0 && group_b_irq_control == '0)
    else $error("flag set before write");
  a_cut_float: assert property (cut && !avs_write && !nmi_n |=>
    (group_a_output_oe_n & 5'h16) == 5'h16)
    else $error("outputs 1 2 4 not floated");
  a_cut_off: assert property (!cut && !avs_write |=> group_a_output_oe_n == '0)
    else $error("floated without cutoff");
  a_nmi_high: assert property (nmi_n |=> group_a_output_oe_n == '0)
    else $error("floated with nmi high");
  a_oe_fixed: assert property (!group_a_output_oe_n[0] && !group_a_output_oe_n[3])
    else $error("channel 0 or 3 floated");
  for (genvar i = 0; i < num_a; i++) begin : g_stop
    a_stop_low: assert property ((!run_a[i])[*4] |-> !group_a_output_pin[i])
      else $error("stopped output high");
  end
  cover property (cut && !nmi_n);
  cover property (avs_read && !avs_waitrequest);
  cover property (|group_a_output_pin);
endmodule // mmtimer_assertions

bind mmtimer mmtimer_assertions mmtimer_assertions_i (.core_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .a_tick, .group_a_input_pin, .b_tick, .b_pulse_in, .nmi_n, .group_a_output_pin,
  .group_a_output_oe_n, .group_a_irq_control, .group_b_irq_control);

/* bench/ext_pulse_model.sv */
`timescale 1ns/100ps
module ext_pulse_model
  import mmtimer_pkg::*;
(
  input wire logic core_clk, // Clock
  output logic [num_a-1:0] a_tick, // A count source
  output logic [num_b-1:0] b_tick, // B count source
  output logic [num_a-1:0] a_in, // A trigger pins
  output logic [num_b-1:0] b_in, // B measured pulses
  output logic nmi_n // Interrupt pin, pulled up
);
  initial begin
    a_tick = '0;
    b_tick = '0;
    a_in = '0;
    b_in = '0;
    nmi_n = 1'b1;
  end
  // ------------
  // Count source pulses
  // ------------
  task automatic ticks(input logic [num_a-1:0] ma, input logic [num_b-1:0] mb, input int n);
    repeat (n) begin
      repeat ($urandom_range(3, 1)) @(posedge core_clk);
      a_tick <= ma;
      b_tick <= mb;
      @(posedge core_clk);
      a_tick <= '0;
      b_tick <= '0;
    end
  endtask
  // Callers keep triggers more than one tick apart
  task automatic pin_a(input int ch, input logic v);
    @(posedge core_clk);
    a_in[ch] <= v;
  endtask
  task automatic pin_b(input int ch, input logic v);
    @(posedge core_clk);
    b_in[ch] <= v;
  endtask
  task automatic set_nmi(input logic v);
    @(posedge core_clk);
    nmi_n <= v;
  endtask
endmodule // ext_pulse_model

/* bench/mmtimer_tb_top.sv */
`timescale 1ns/100ps
module mmtimer_tb_top
  import mmtimer_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [num_a-1:0] a_tick;
  logic [num_a-1:0] a_in;
  logic [num_b-1:0] b_tick;
  logic [num_b-1:0] b_in;
  logic nmi_n;
  logic [num_a-1:0] a_out;
  logic [num_a-1:0] a_oe_n;
  logic [num_a-1:0] a_irq;
  logic [num_b-1:0] b_irq;
  int n_errors = 0;
  int n_compared = 0;
  int exp_cnt [num_a+num_b];
  logic [7:0] from_md [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0] to_md [5] = '{8'h02, 8'h03, 8'h02, 8'h03, 8'h01};
  logic [15:0] n_ld;
  always #10 core_clk = ~core_clk;
  mmtimer mmtimer_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .a_tick(a_tick), .group_a_input_pin(a_in),
    .b_tick(b_tick), .b_pulse_in(b_in), .nmi_n(nmi_n), .group_a_output_pin(a_out),
    .group_a_output_oe_n(a_oe_n), .group_a_irq_control(a_irq), .group_b_irq_control(b_irq));
  ext_pulse_model ext_pulse_model_i (.core_clk(core_clk), .a_tick(a_tick), .b_tick(b_tick),
    .a_in(a_in), .b_in(b_in), .nmi_n(nmi_n));
  // ------------
  // Bus and compare tasks
  // ------------
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask
  function automatic logic [7:0] cnt_adr(input int i);
    return (i < num_a) ? a_count_base + 8'(4 * i) : b_count_base + 8'(4 * (i - num_a));
  endfunction
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
  // ------------
  // Scenarios
  // ------------
  initial begin
    void'($urandom(15));
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    ext_pulse_model_i.ticks(5'h1f, 6'h3f, 3);
    rd_chk("irq_flags", irq_flags_off, 32'h0);
    rd_chk("pin_status", pin_status_off, 32'h0);
    wr(8'hfc, 32'hffffffff);
    rd_chk("unmapped", 8'hfc, 32'h0);
    for (int i = 0; i < num_a + num_b; i++) begin
      exp_cnt[i] = $urandom_range(16'hffff, 16'h0100);
      wr(cnt_adr(i), {16'($urandom), 16'(exp_cnt[i])});
    end
    ext_pulse_model_i.ticks(5'h1f, 6'h3f, 4);
    for (int i = 0; i < num_a + num_b; i++) rd_chk("count", cnt_adr(i), exp_cnt[i]);
    wr(start_first_off, 32'h000000ff);
    wr(start_second_off, 32'h000000e0);
    ext_pulse_model_i.ticks(5'h1f, 6'h3f, 5);
    wr(start_first_off, 32'h0);
    wr(start_second_off, 32'h0);
    for (int i = 0; i < num_a + num_b; i++) begin
      exp_cnt[i] -= 5;
      rd_chk("count_run", cnt_adr(i), exp_cnt[i]);
    end
    for (int c = 0; c < num_a; c++) begin
      wr(a_mode_base + 8'(4 * c), {24'h0, from_md[c]});
      wr(irq_flags_off, 32'h0);
      wr(a_mode_base + 8'(4 * c), {24'h0, to_md[c]});
      repeat (3) @(posedge core_clk);
      rd_chk("mode_irq", irq_flags_off, (c < 4) ? 32'h1 << c : 32'h0);
    end
    n_ld = 16'($urandom_range(200, 16));
    wr(cnt_adr(0), {16'h0, n_ld});
    wr(irq_flags_off, 32'h0);
    wr(start_first_off, 32'h1);
    ext_pulse_model_i.pin_a(0, 1'b1);
    ext_pulse_model_i.ticks(5'h01, 6'h0, 2);
    rd_chk("oneshot_out", pin_status_off, 32'h1);
    wr(start_first_off, 32'h0);
    repeat (3) @(posedge core_clk);
    rd_chk("oneshot_stop", pin_status_off, 32'h0);
    rd_chk("oneshot_irq", irq_flags_off, 32'h1);
    rd_chk("oneshot_reload", cnt_adr(0), {16'h0, n_ld});
    ext_pulse_model_i.pin_a(0, 1'b0);
    wr(cnt_adr(1), {16'h0, n_ld});
    wr(start_first_off, 32'h2);
    ext_pulse_model_i.pin_a(1, 1'b1);
    ext_pulse_model_i.ticks(5'h02, 6'h0, 2);
    wr(irq_flags_off, 32'h0);
    rd_chk("pwm_high", pin_status_off, 32'h2);
    wr(start_first_off, 32'h0);
    repeat (3) @(posedge core_clk);
    rd_chk("pwm_stop", pin_status_off, 32'h0);
    rd_chk("pwm_irq", irq_flags_off, 32'h2);
    wr(irq_flags_off, 32'h0);
    wr(start_first_off, 32'h2);
    wr(start_first_off, 32'h0);
    repeat (3) @(posedge core_clk);
    rd_chk("pwm_low_irq", irq_flags_off, 32'h0);
    ext_pulse_model_i.pin_a(1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(cutoff_ctrl_off, 32'(k / 2));
      ext_pulse_model_i.set_nmi(k[0]);
      repeat (3) @(posedge core_clk);
      rd_chk("cutoff", pin_status_off, (k == 2) ? 32'h1600 : 32'h0);
      ext_pulse_model_i.set_nmi(1'b1);
    end
    wr(cutoff_ctrl_off, 32'h0);
    for (int w = 0; w < 2; w++) begin
      wr(b_mode_base + 8'(4 * (3 + w)), w ? 32'h22 : 32'h02);
      wr(irq_flags_off, 32'h0);
      wr(start_second_off, 32'h20 << w);
      ext_pulse_model_i.pin_b(3 + w, 1'b1);
      ext_pulse_model_i.ticks(5'h0, 6'h08 << w, 3);
      rd_chk("meas_first", irq_flags_off, 32'h0);
      ext_pulse_model_i.pin_b(3 + w, 1'b0);
      ext_pulse_model_i.ticks(5'h0, 6'h08 << w, 3);
      rd_chk("meas_fall", irq_flags_off, w ? 32'h800 << w : 32'h0);
      wr(irq_flags_off, 32'h0);
      ext_pulse_model_i.pin_b(3 + w, 1'b1);
      ext_pulse_model_i.ticks(5'h0, 6'h08 << w, 3);
      rd_chk("meas_rise", irq_flags_off, 32'h800 << w);
      wr(start_second_off, 32'h0);
      ext_pulse_model_i.pin_b(3 + w, 1'b0);
    end
    tally_and_finish();
  end
endmodule // mmtimer_tb_top
